/* design/csmc_pkg.sv */
// Constants for the clock and supply monitor control block.
// Assumes a 32-bit APB register bus and one system clock.
// How it works
// - Trim code is eight bits, low byte, resets to all ones.
// - After reset crystal is the clock source and PLL is enabled but not selected.
// - Source codes 00, 01, 10 pick crystal; 11 picks PLL.
// - Driver enables read fixed: bits 17 and 16 one, 19 and 18 zero.
// - PLL reference select reads fixed one, the crystal.
// - PLL enable resets to one; dividers and multiplier reset to zero.
// - Detector off after reset; bit 15 powers it on.
// - With bit 17 set, a low supply raises the interrupt.
// - With bit 16 set, a low supply requests a system reset.
// - Low-voltage flag at bit 0 sets and sticks until software clears it.
// - Seven-bit threshold at 14-8 sets the detection level uniformly.
package csmc_pkg;
    localparam logic [7:0] ADDR_TRIM = 8'h00;
    localparam logic [7:0] ADDR_OSC = 8'h04;
    localparam logic [7:0] ADDR_PLL = 8'h08;
    localparam logic [7:0] ADDR_LVD = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
    localparam logic [7:0] TRIM_RESET = 8'hFF;
    localparam logic [1:0] CLKSRC_RESET = 2'h0;
    localparam logic [1:0] CLKSRC_PLL = 2'h3;
    localparam int OSC_SRC_LSB = 24;
    localparam int OSC_DRV_LSB = 16;
    localparam logic [3:0] OSC_DRV_FIXED = 4'h3;
    localparam int OSC_CTRIM_LSB = 8;
    localparam int PLL_EN_BIT = 31;
    localparam int PLL_REF_BIT = 24;
    localparam int PLL_PRE_LSB = 20;
    localparam int PLL_POST_LSB = 16;
    localparam int PLL_MUL_LSB = 8;
    localparam logic PLL_EN_RESET = 1'b1;
    localparam int LVD_IRQ_EN_BIT = 17;
    localparam int LVD_RST_EN_BIT = 16;
    localparam int LVD_ON_BIT = 15;
    localparam int LVD_THR_LSB = 8;
    localparam int LVD_FLAG_BIT = 0;
    localparam int LVD_RST_PULSE = 4;
endpackage : csmc_pkg

/* design/csmc_sync.sv */
// Two-flop synchroniser for an asynchronous level.
// Assumes the input may change at any time relative to pclk.
`timescale 1ns/10ps
module csmc_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Level
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : csmc_sync

/* design/csmc_edge.sv */
// Rising edge detector on a synchronous level.
// Assumes the input is already in the pclk domain.
`timescale 1ns/10ps
module csmc_edge (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Level in, pulse out
    input wire logic level_in,
    output logic rise_out
);
    logic last_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= level_in;
        end
    end
    assign rise_out = level_in & ~last_reg;
endmodule : csmc_edge

/* design/csmc_ctrl.sv */
// Control registers for regulator trim, clock source, PLL and low-voltage detector.
// Assumes an APB master on pclk and an asynchronous comparator output from the detector.
`timescale 1ns/10ps
module csmc_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog macro controls
    output logic [7:0] supply_trim_code,
    output logic [1:0] clock_source_select,
    output logic pll_select,
    output logic [1:0] int_osc_coarse_trim,
    output logic [7:0] int_osc_fine_trim,
    output logic pll_enable_bit,
    output logic [3:0] pll_pre_divider,
    output logic [3:0] pll_post_divider,
    output logic [7:0] pll_multiplier,
    output logic [7:0] pll_divider,
    output logic lowv_detector_on,
    output logic [6:0] lowv_threshold,
    // Detector input and system outputs
    input wire logic lowv_compare_async,
    output logic irq,
    output logic lowv_reset_req
);
    import csmc_pkg::*;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0] trim_reg;
    logic [1:0] src_reg;
    logic [1:0] ctrim_reg;
    logic [7:0] ftrim_reg;
    logic pll_en_reg;
    logic [3:0] pre_reg;
    logic [3:0] post_reg;
    logic [7:0] mul_reg;
    logic [7:0] div_reg;
    logic lv_irq_en_reg;
    logic lv_rst_en_reg;
    logic lv_on_reg;
    logic [6:0] lv_thr_reg;
    logic lv_flag_reg;
    logic irq_en_reg;
    logic [2:0] rst_cnt_reg;
    logic [2:0] rst_cnt_next;
    logic low_sync;
    logic low_rise;
    logic low_event;
    logic wr_access;
    logic rd_access;
    logic addr_ok;
    logic [31:0] rd_next;
    logic [31:0] wmask;
    logic wr_trim;
    logic wr_osc;
    logic wr_pll;
    logic wr_lvd;
    logic wr_irq_en;
    logic wr_irq_clr;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign addr_ok = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0) && (paddr[7:0] <= ADDR_IRQ_CLR);
    assign wr_access = psel && penable && pwrite && addr_ok;
    assign rd_access = psel && !penable && !pwrite;
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wr_trim = wr_access && (paddr[7:0] == ADDR_TRIM);
    assign wr_osc = wr_access && (paddr[7:0] == ADDR_OSC);
    assign wr_pll = wr_access && (paddr[7:0] == ADDR_PLL);
    assign wr_lvd = wr_access && (paddr[7:0] == ADDR_LVD);
    assign wr_irq_en = wr_access && (paddr[7:0] == ADDR_IRQ_EN);
    assign wr_irq_clr = wr_access && (paddr[7:0] == ADDR_IRQ_CLR);

    // ----------------------------------------
    // Detector input path
    // ----------------------------------------
    csmc_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(lowv_compare_async),
        .sync_out(low_sync)
    );

    csmc_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level_in(low_sync),
        .rise_out(low_rise)
    );

    // Detection counts only while the detector is powered.
    assign low_event = low_rise && lv_on_reg;

    // ----------------------------------------
    // Trim register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_reg <= TRIM_RESET;
        end else if (wr_trim) begin
            trim_reg <= (trim_reg & ~wmask[7:0]) | (pwdata[7:0] & wmask[7:0]);
        end
    end

    // ----------------------------------------
    // Oscillator register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_reg <= CLKSRC_RESET;
            ctrim_reg <= 2'h0;
            ftrim_reg <= 8'h00;
        end else if (wr_osc) begin
            if (pstrb[3]) begin
                src_reg <= pwdata[OSC_SRC_LSB +: 2];
            end
            if (pstrb[1]) begin
                ctrim_reg <= pwdata[OSC_CTRIM_LSB +: 2];
            end
            if (pstrb[0]) begin
                ftrim_reg <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // PLL register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_en_reg <= PLL_EN_RESET;
            pre_reg <= 4'h0;
            post_reg <= 4'h0;
            mul_reg <= 8'h00;
            div_reg <= 8'h00;
        end else if (wr_pll) begin
            if (pstrb[3]) begin
                pll_en_reg <= pwdata[PLL_EN_BIT];
            end
            if (pstrb[2]) begin
                pre_reg <= pwdata[PLL_PRE_LSB +: 4];
                post_reg <= pwdata[PLL_POST_LSB +: 4];
            end
            if (pstrb[1]) begin
                mul_reg <= pwdata[PLL_MUL_LSB +: 8];
            end
            if (pstrb[0]) begin
                div_reg <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Low-voltage configuration
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_irq_en_reg <= 1'b0;
            lv_rst_en_reg <= 1'b0;
            lv_on_reg <= 1'b0;
            lv_thr_reg <= 7'h00;
        end else if (wr_lvd) begin
            if (pstrb[2]) begin
                lv_irq_en_reg <= pwdata[LVD_IRQ_EN_BIT];
                lv_rst_en_reg <= pwdata[LVD_RST_EN_BIT];
            end
            if (pstrb[1]) begin
                lv_on_reg <= pwdata[LVD_ON_BIT];
                lv_thr_reg <= pwdata[LVD_THR_LSB +: 7];
            end
        end
    end

    // ----------------------------------------
    // Sticky low-voltage flag
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_flag_reg <= 1'b0;
        end else if (low_event) begin
            lv_flag_reg <= 1'b1;
        end else if (wr_lvd && pstrb[0] && !pwdata[LVD_FLAG_BIT]) begin
            lv_flag_reg <= 1'b0;
        end else if (wr_irq_clr && pstrb[0] && pwdata[0]) begin
            lv_flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interrupt enable and output
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_reg <= 1'b1;
        end else if (wr_irq_en && pstrb[0]) begin
            irq_en_reg <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= lv_flag_reg && lv_irq_en_reg && irq_en_reg;
        end
    end

    // ----------------------------------------
    // Reset request pulse
    // ----------------------------------------
    always_comb begin
        rst_cnt_next = rst_cnt_reg;
        if (low_event && lv_rst_en_reg) begin
            rst_cnt_next = 3'(LVD_RST_PULSE);
        end else if (rst_cnt_reg != 3'h0) begin
            rst_cnt_next = rst_cnt_reg - 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_reg <= 3'h0;
            lowv_reset_req <= 1'b0;
        end else begin
            rst_cnt_reg <= rst_cnt_next;
            lowv_reset_req <= (rst_cnt_next != 3'h0);
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        rd_next = 32'h00000000;
        case (paddr[7:0])
            ADDR_TRIM: rd_next = {24'h000000, trim_reg};
            ADDR_OSC: begin
                rd_next[OSC_SRC_LSB +: 2] = src_reg;
                rd_next[OSC_DRV_LSB +: 4] = OSC_DRV_FIXED;
                rd_next[OSC_CTRIM_LSB +: 2] = ctrim_reg;
                rd_next[7:0] = ftrim_reg;
            end
            ADDR_PLL: begin
                rd_next[PLL_EN_BIT] = pll_en_reg;
                rd_next[PLL_REF_BIT] = 1'b1;
                rd_next[PLL_PRE_LSB +: 4] = pre_reg;
                rd_next[PLL_POST_LSB +: 4] = post_reg;
                rd_next[PLL_MUL_LSB +: 8] = mul_reg;
                rd_next[7:0] = div_reg;
            end
            ADDR_LVD: begin
                rd_next[LVD_IRQ_EN_BIT] = lv_irq_en_reg;
                rd_next[LVD_RST_EN_BIT] = lv_rst_en_reg;
                rd_next[LVD_ON_BIT] = lv_on_reg;
                rd_next[LVD_THR_LSB +: 7] = lv_thr_reg;
                rd_next[LVD_FLAG_BIT] = lv_flag_reg;
            end
            ADDR_IRQ_STAT: rd_next[0] = lv_flag_reg;
            ADDR_IRQ_EN: rd_next[0] = irq_en_reg;
            default: rd_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_access) begin
            prdata <= addr_ok ? rd_next : 32'h00000000;
        end
    end

    // ----------------------------------------
    // Transfer response
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // ----------------------------------------
    // Regulator and oscillator outputs
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_trim_code <= TRIM_RESET;
            clock_source_select <= CLKSRC_RESET;
            pll_select <= 1'b0;
            int_osc_coarse_trim <= 2'h0;
            int_osc_fine_trim <= 8'h00;
        end else begin
            supply_trim_code <= trim_reg;
            clock_source_select <= src_reg;
            pll_select <= (src_reg == CLKSRC_PLL);
            int_osc_coarse_trim <= ctrim_reg;
            int_osc_fine_trim <= ftrim_reg;
        end
    end

    // ----------------------------------------
    // PLL outputs
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_enable_bit <= PLL_EN_RESET;
            pll_pre_divider <= 4'h0;
            pll_post_divider <= 4'h0;
            pll_multiplier <= 8'h00;
            pll_divider <= 8'h00;
        end else begin
            pll_enable_bit <= pll_en_reg;
            pll_pre_divider <= pre_reg;
            pll_post_divider <= post_reg;
            pll_multiplier <= mul_reg;
            pll_divider <= div_reg;
        end
    end

    // ----------------------------------------
    // Detector outputs
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lowv_detector_on <= 1'b0;
            lowv_threshold <= 7'h00;
        end else begin
            lowv_detector_on <= lv_on_reg;
            lowv_threshold <= lv_thr_reg;
        end
    end
endmodule : csmc_ctrl

/* test/csmc_props.sv */
// Port-level assertions for the clock and supply monitor control block.
// Assumes one pclk domain and the bind placed after the module.
`timescale 1ns/10ps
module csmc_props
    import csmc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Macro side
    input wire logic [7:0] supply_trim_code,
    input wire logic [1:0] clock_source_select,
    input wire logic pll_select,
    input wire logic lowv_detector_on,
    input wire logic [6:0] lowv_threshold,
    input wire logic lowv_compare_async,
    input wire logic irq,
    input wire logic lowv_reset_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wr(logic [7:0] a, int b);
        psel && penable && pready && pwrite && paddr == {24'h0, a} && pstrb[b];
    endsequence
    sequence s_rd(logic [7:0] a);
        psel && penable && pready && !pwrite && paddr == {24'h0, a};
    endsequence
    property p_trim;
        s_wr(ADDR_TRIM, 0) |-> ##2 supply_trim_code == $past(pwdata[7:0], 2);
    endproperty
    a_trim: assert property (p_trim) else $error("trim output mismatch");
    property p_osc_ro;
        s_rd(ADDR_OSC) |-> prdata[19:16] == OSC_DRV_FIXED && prdata[31:26] == 6'h00;
    endproperty
    a_osc_ro: assert property (p_osc_ro) else $error("driver bits wrong");
    property p_pll_ref;
        s_rd(ADDR_PLL) |-> prdata[24] && prdata[30:25] == 6'h00;
    endproperty
    a_pll_ref: assert property (p_pll_ref) else $error("pll reference bit wrong");
    property p_src;
        pll_select == (clock_source_select == CLKSRC_PLL);
    endproperty
    a_src: assert property (p_src) else $error("source decode wrong");
    property p_lvd;
        s_wr(ADDR_LVD, 1) |-> ##2 lowv_threshold == $past(pwdata[14:8], 2) && lowv_detector_on == $past(pwdata[15], 2);
    endproperty
    a_lvd: assert property (p_lvd) else $error("detector controls wrong");
    property p_rst;
        $rose(lowv_reset_req) |-> lowv_reset_req[*4];
    endproperty
    a_rst: assert property (p_rst) else $error("reset request too short");
    property p_sync;
        $rose(lowv_compare_async) && !irq |=> (!irq)[*2];
    endproperty
    a_sync: assert property (p_sync) else $error("compare used unsynchronised");
    property p_sticky;
        irq && !$past(psel && penable && pwrite) && !$past(psel && penable && pwrite, 2) |=> irq;
    endproperty
    a_sticky: assert property (p_sticky) else $error("interrupt dropped without write");
endmodule : csmc_props

bind csmc_ctrl csmc_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .supply_trim_code(supply_trim_code), .clock_source_select(clock_source_select),
    .pll_select(pll_select), .lowv_detector_on(lowv_detector_on), .lowv_threshold(lowv_threshold),
    .lowv_compare_async(lowv_compare_async), .irq(irq), .lowv_reset_req(lowv_reset_req)
);

/* test/csmc_lowv_model.sv */
// Behavioural comparator of the low-voltage detector.
// Assumes the bench sets the supply level in millivolts; output is meaningless while unpowered.
`timescale 1ns/10ps
module csmc_lowv_model (
    // Detector controls
    input wire logic [6:0] lowv_threshold,
    input wire logic [31:0] supply_mv,
    // Comparator output
    output logic lowv_compare_async
);
    logic [31:0] trip;
    assign trip = 32'h9C4 + ({25'h0, lowv_threshold} * 32'h9C4) / 32'h7F;
    assign #3 lowv_compare_async = supply_mv < trip;
endmodule : csmc_lowv_model

/* test/tb_top.sv */
// Self-checking bench for the clock and supply monitor control block.
// Assumes the checker binds itself and the comparator model stands beside the design.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    import csmc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] supply_mv = 32'h15E0;
    logic [31:0] prdata, rdat, d;
    logic pready, pslverr, rerr, pll_select, pll_enable_bit, lowv_detector_on;
    logic lowv_compare_async, irq, lowv_reset_req;
    logic [7:0] supply_trim_code, int_osc_fine_trim, pll_multiplier, pll_divider, a;
    logic [1:0] clock_source_select, int_osc_coarse_trim;
    logic [3:0] pll_pre_divider, pll_post_divider;
    logic [6:0] lowv_threshold, t;
    logic [31:0] rst_v [4] = '{32'h000000FF, 32'h00030000, 32'h81000000, 32'h0};
    int seed = 47718;
    int error_cnt = 0;
    int samples_checked = 0;
    int cnt;
    always #5 pclk = ~pclk;
    csmc_ctrl dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_trim_code(supply_trim_code), .clock_source_select(clock_source_select),
        .pll_select(pll_select), .int_osc_coarse_trim(int_osc_coarse_trim),
        .int_osc_fine_trim(int_osc_fine_trim), .pll_enable_bit(pll_enable_bit),
        .pll_pre_divider(pll_pre_divider), .pll_post_divider(pll_post_divider),
        .pll_multiplier(pll_multiplier), .pll_divider(pll_divider), .lowv_detector_on(lowv_detector_on),
        .lowv_threshold(lowv_threshold), .lowv_compare_async(lowv_compare_async), .irq(irq),
        .lowv_reset_req(lowv_reset_req)
    );
    csmc_lowv_model u_model (
        .lowv_threshold(lowv_threshold), .supply_mv(supply_mv), .lowv_compare_async(lowv_compare_async)
    );
    task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] wd, input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, ad};
        pwdata <= wd;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v && n < 32) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_irq
    function automatic logic [31:0] exp_reg(input logic [7:0] ad, input logic [31:0] wd);
        if (ad == ADDR_TRIM)
            return {24'h0, wd[7:0]};
        if (ad == ADDR_OSC)
            return (wd & 32'h030003FF) | 32'h00030000;
        return (wd & 32'h80FFFFFF) | 32'h01000000;
    endfunction : exp_reg
    function automatic logic [31:0] trip_mv(input logic [6:0] th);
        return 32'h9C4 + ({25'h0, th} * 32'h9C4) / 32'h7F;
    endfunction : trip_mv
    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        #300000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(8'(4 * i), 1'b0, 32'h0, 4'hF);
            `CHK("reset", rst_v[i], rdat)
        end
        `CHK("trim_out", 8'hFF, supply_trim_code)
        `CHK("src_out", 3'h0, {pll_select, clock_source_select})
        apb(ADDR_TRIM, 1'b1, 32'hFFFFFF5A, 4'h1);
        apb(ADDR_TRIM, 1'b0, 32'h0, 4'hF);
        `CHK("trim_load", 40'h5A0000005A, {supply_trim_code, rdat})
        for (int i = 0; i < 12; i++) begin
            a = 8'(4 * (i % 3));
            d = $random(seed);
            if (a == ADDR_OSC)
                d[25] = 1'b0;
            if (a == ADDR_PLL)
                d[31] = 1'b0;
            apb(a, 1'b1, d, 4'hF);
            apb(a, 1'b0, 32'h0, 4'hF);
            `CHK("readback", exp_reg(a, d), rdat)
        end
        `CHK("mul_out", d[15:8], pll_multiplier)
        apb(ADDR_PLL, 1'b1, 32'h80111902, 4'hF);
        repeat (16) @(posedge pclk);
        `CHK("pll_out", 9'h111, {pll_enable_bit, pll_pre_divider, pll_post_divider})
        `CHK("pll_mul", 16'h1902, {pll_multiplier, pll_divider})
        apb(ADDR_PLL, 1'b1, 32'h7EEE1AFD, 4'h2);
        apb(ADDR_PLL, 1'b0, 32'h0, 4'hF);
        `CHK("pll_lane", 32'h81111A02, rdat)
        for (int c = 0; c < 4; c++) begin
            apb(ADDR_OSC, 1'b1, {6'h00, 2'(c), 14'h0, 2'(c), 8'(8'hA0 + c)}, 4'hF);
            apb(ADDR_OSC, 1'b0, 32'h0, 4'hF);
            `CHK("pll_select", c == 3, pll_select)
            `CHK("src_sel", 2'(c), clock_source_select)
            `CHK("osc_trim", {2'(c), 8'(8'hA0 + c)}, {int_osc_coarse_trim, int_osc_fine_trim})
        end
        apb(8'h1C, 1'b0, 32'h0, 4'hF);
        `CHK("unmapped", 33'h100000000, {rerr, rdat})
        supply_mv <= 32'h7D0;
        repeat (20) @(posedge pclk);
        apb(ADDR_IRQ_STAT, 1'b0, 32'h0, 4'hF);
        `CHK("off_flag", 32'h0, rdat)
        supply_mv <= 32'h15E0;
        t = 7'($random(seed));
        apb(ADDR_LVD, 1'b1, {14'h0, 2'b10, 1'b1, t, 8'h00}, 4'hF);
        repeat (1000) @(posedge pclk);
        `CHK("lvd_out", {1'b1, t}, {lowv_detector_on, lowv_threshold})
        `CHK("irq_idle", 1'b0, irq)
        supply_mv <= trip_mv(t) - 32'h1;
        wait_irq(1'b1);
        `CHK("irq_set", 1'b1, irq)
        supply_mv <= 32'h15E0;
        apb(ADDR_LVD, 1'b0, 32'h0, 4'hF);
        `CHK("lvd_flag", {14'h0, 2'b10, 1'b1, t, 8'h01}, rdat)
        apb(ADDR_IRQ_EN, 1'b1, 32'h0, 4'hF);
        wait_irq(1'b0);
        `CHK("irq_mask", 1'b0, irq)
        apb(ADDR_IRQ_EN, 1'b1, 32'h1, 4'hF);
        wait_irq(1'b1);
        `CHK("irq_unmask", 1'b1, irq)
        apb(ADDR_IRQ_CLR, 1'b1, 32'h1, 4'hF);
        wait_irq(1'b0);
        apb(ADDR_IRQ_STAT, 1'b0, 32'h0, 4'hF);
        `CHK("flag_clr", 33'h0, {irq, rdat})
        apb(ADDR_LVD, 1'b1, {14'h0, 2'b01, 1'b1, t, 8'h00}, 4'hF);
        supply_mv <= trip_mv(t) - 32'h1;
        cnt = 0;
        repeat (24) begin
            @(posedge pclk);
            cnt += int'(lowv_reset_req === 1'b1);
        end
        `CHK("rst_len", 4, cnt)
        apb(ADDR_IRQ_STAT, 1'b0, 32'h0, 4'hF);
        `CHK("flag_noirq", 33'h1, {irq, rdat})
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(ADDR_IRQ_STAT, 1'b0, 32'h0, 4'hF);
        `CHK("rerst", {1'b0, TRIM_RESET, 32'h0}, {lowv_reset_req, supply_trim_code, rdat})
        complete_run();
    end
endmodule : tb_top
